// >>> common/cap2_aer_pkg.sv
// Summary of operation
// - Device control two: LTR and OBFF enables only
// - De-emphasis bits fixed by port direction
// - Error header bits 15:0 read 0001h
// - Error header bits 19:16 read version 1h
// - Error header next pointer reads 140h
// - Training error sets sticky W1C bit 0
// - Data link protocol error sets bit 4
// - Poisoned TLP sets bit 12
// - Flow control protocol error sets bit 13
// - Completion timeout sets bit 14
// - Completer abort sets bit 15
// - Unexpected completion sets bit 16
// - Receive buffer overflow sets bit 17
// - Malformed TLP sets bit 18
// - End-to-end CRC failure sets bit 19
// - Unsupported request sets bit 20
// - Access control violation sets bit 21
// - Mask bit suppresses logging and error message
package cap2_aer_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_DEV_CTRL2 = 12'h0e8;
    localparam logic [11:0] OFS_LINK_CAP2 = 12'h0ec;
    localparam logic [11:0] OFS_LINK_CTRL2 = 12'h0f0;
    localparam logic [11:0] OFS_SLOT_CAP2 = 12'h0f4;
    localparam logic [11:0] OFS_SLOT_CTRL2 = 12'h0f8;
    localparam logic [11:0] OFS_AER_HDR = 12'h100;
    localparam logic [11:0] OFS_UE_STATUS = 12'h104;
    localparam logic [11:0] OFS_UE_MASK = 12'h108;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int DC2_LTR_EN = 10;
    localparam int DC2_OBFF_LSB = 13;
    localparam int OBFF_W = 2;
    localparam int LC2_SPEED_LSB = 0;
    localparam int SPEED_W = 4;
    localparam int LC2_ENTER_COMPL = 4;
    localparam int LC2_HW_SPEED_DIS = 5;
    localparam int LC2_SEL_DEEMPH = 6;
    localparam int LC2_MARGIN_LSB = 7;
    localparam int MARGIN_W = 3;
    localparam int LC2_MOD_COMPL = 10;
    localparam int LC2_COMPL_SOS = 11;
    localparam int LC2_COMPL_DEEMPH = 12;
    localparam int LS2_CUR_DEEMPH = 16;
    localparam int HDR_ID_LSB = 0;
    localparam int HDR_VER_LSB = 16;
    localparam int HDR_NEXT_LSB = 20;
    localparam int BYTE_W = 8;

    ////////////////////////////////////////////////////////////////////////
    // Reset and fixed values
    localparam logic [3:0] SPEED_RST = 4'h2;
    localparam logic [2:0] MARGIN_RST = 3'h0;
    localparam logic [1:0] OBFF_RST = 2'h0;
    localparam logic [15:0] AER_CAP_ID = 16'h0001;
    localparam logic [3:0] AER_CAP_VER = 4'h1;
    localparam logic [11:0] AER_NEXT_PTR = 12'h140;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Uncorrectable error bit positions
    localparam int UE_TRAINING = 0;
    localparam int UE_DL_PROTOCOL = 4;
    localparam int UE_POISONED = 12;
    localparam int UE_FC_PROTOCOL = 13;
    localparam int UE_CPL_TIMEOUT = 14;
    localparam int UE_CPL_ABORT = 15;
    localparam int UE_UNEXP_CPL = 16;
    localparam int UE_RX_OVERFLOW = 17;
    localparam int UE_MALFORMED = 18;
    localparam int UE_ECRC = 19;
    localparam int UE_UNSUP_REQ = 20;
    localparam int UE_ACS = 21;
    localparam logic [31:0] UE_IMPL_MASK = 32'h003f_f011;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [1:0] obff_enable;       // OBFF enable and method
        logic ltr_enable;              // Latency tolerance reporting
    } dev_ctrl_t;

    typedef struct packed {
        logic [3:0] target_link_speed;
        logic enter_compliance;
        logic hw_speed_change_disable;
        logic [2:0] transmit_margin;
        logic enter_modified_compliance;
        logic compliance_skip_ordered_sets;
        logic compliance_deemphasis;
    } link_ctrl_t;

    typedef struct packed {
        logic acs_violation;
        logic unsupported_request;
        logic ecrc_error;
        logic malformed_tlp;
        logic receiver_overflow;
        logic unexpected_completion;
        logic completer_abort;
        logic completion_timeout;
        logic fc_protocol_error;
        logic poisoned_tlp;
        logic dl_protocol_error;
        logic training_error;
    } uncor_event_t;

endpackage

// >>> hdl/cap2_aer_regs.sv
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/100ps
module cap2_aer_regs
    import cap2_aer_pkg::*;
#(
    parameter bit DOWNSTREAM_PORT = 1'b0  // Port direction strap
) (
    input wire logic clock,                    // Core clock, 25 MHz
    input wire logic rstn,                     // Conventional reset, low
    input wire logic sticky_rstn,              // Sticky reset, low
    input wire logic [ADDR_W-1:0] avs_address, // Byte address
    input wire logic avs_read,                 // Read request
    input wire logic avs_write,                // Write request
    input wire logic [31:0] avs_writedata,     // Write data
    input wire logic [3:0] avs_byteenable,     // Byte lanes
    output logic [31:0] avs_readdata,          // Read data
    output logic avs_waitrequest,              // Stall
    input wire uncor_event_t uncor_events,     // Error event pulses
    output dev_ctrl_t dev_ctrl,                // Device control fields
    output link_ctrl_t link_ctrl,              // Link control fields
    output logic header_log_req,               // Log header pulse
    output logic error_msg_req                 // Send message pulse
);

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Word decode, shared by read and write paths
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
        hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    endfunction

    // Byte enables widened to a bit mask
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        logic [31:0] m;
        m = WORD_ZERO;
        for (int i = 0; i < 4; i++) begin
            m[i*BYTE_W +: BYTE_W] = {BYTE_W{be[i]}};
        end
        be_mask = m;
    endfunction

    // Error events placed at their status positions
    function automatic logic [31:0] uncor_word(input uncor_event_t e);
        logic [31:0] w;
        w = WORD_ZERO;
        w[UE_TRAINING] = e.training_error;
        w[UE_DL_PROTOCOL] = e.dl_protocol_error;
        w[UE_POISONED] = e.poisoned_tlp;
        w[UE_FC_PROTOCOL] = e.fc_protocol_error;
        w[UE_CPL_TIMEOUT] = e.completion_timeout;
        w[UE_CPL_ABORT] = e.completer_abort;
        w[UE_UNEXP_CPL] = e.unexpected_completion;
        w[UE_RX_OVERFLOW] = e.receiver_overflow;
        w[UE_MALFORMED] = e.malformed_tlp;
        w[UE_ECRC] = e.ecrc_error;
        w[UE_UNSUP_REQ] = e.unsupported_request;
        w[UE_ACS] = e.acs_violation;
        uncor_word = w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [31:0] ue_status;      // Sticky error status
    logic [31:0] ue_mask;        // Sticky error mask
    logic [31:0] ue_set;         // Events this cycle
    logic [31:0] wmask;          // Write lane mask
    logic [31:0] ue_clear;       // W1C clear bits
    logic [31:0] next_status;    // Status next value
    logic [31:0] lc2_word;       // Link control/status two view
    logic [31:0] dc2_word;       // Device control two view
    logic [31:0] hdr_word;       // Error capability header
    logic [31:0] lc2_merge;      // Link control after write
    logic [31:0] dc2_merge;      // Device control after write
    logic [31:0] read_word;      // Read mux result
    logic wr_fire;               // Write takes effect
    logic rd_take;               // Read accepted this cycle
    logic deemph_level;          // Fixed de-emphasis value

    ////////////////////////////////////////////////////////////////////////
    // Avalon handshake

    // One wait cycle per access; the answer comes on the next edge
    always_ff @(posedge clock) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    assign wr_fire = avs_write && !avs_waitrequest;
    assign rd_take = avs_read && avs_waitrequest;
    assign wmask = be_mask(avs_byteenable);

    ////////////////////////////////////////////////////////////////////////
    // Read views

    // Direction strap fixes both de-emphasis bits
    assign deemph_level = DOWNSTREAM_PORT;

    // Device control two, status half reads zero
    always_comb begin
        dc2_word = WORD_ZERO;
        dc2_word[DC2_LTR_EN] = dev_ctrl.ltr_enable;
        dc2_word[DC2_OBFF_LSB +: OBFF_W] = dev_ctrl.obff_enable;
    end

    // Link control and status two
    always_comb begin
        lc2_word = WORD_ZERO;
        lc2_word[LC2_SPEED_LSB +: SPEED_W] = link_ctrl.target_link_speed;
        lc2_word[LC2_ENTER_COMPL] = link_ctrl.enter_compliance;
        lc2_word[LC2_HW_SPEED_DIS] = link_ctrl.hw_speed_change_disable;
        lc2_word[LC2_SEL_DEEMPH] = deemph_level;
        lc2_word[LC2_MARGIN_LSB +: MARGIN_W] = link_ctrl.transmit_margin;
        lc2_word[LC2_MOD_COMPL] = link_ctrl.enter_modified_compliance;
        lc2_word[LC2_COMPL_SOS] = link_ctrl.compliance_skip_ordered_sets;
        lc2_word[LC2_COMPL_DEEMPH] = link_ctrl.compliance_deemphasis;
        lc2_word[LS2_CUR_DEEMPH] = deemph_level;
    end

    // Error capability header, all constant
    always_comb begin
        hdr_word = WORD_ZERO;
        hdr_word[HDR_ID_LSB +: 16] = AER_CAP_ID;
        hdr_word[HDR_VER_LSB +: 4] = AER_CAP_VER;
        hdr_word[HDR_NEXT_LSB +: 12] = AER_NEXT_PTR;
    end

    // Read mux; capability and slot words and holes read zero
    always_comb begin
        if (hit(avs_address, OFS_DEV_CTRL2)) begin
            read_word = dc2_word;
        end else if (hit(avs_address, OFS_LINK_CTRL2)) begin
            read_word = lc2_word;
        end else if (hit(avs_address, OFS_AER_HDR)) begin
            read_word = hdr_word;
        end else if (hit(avs_address, OFS_UE_STATUS)) begin
            read_word = ue_status;
        end else if (hit(avs_address, OFS_UE_MASK)) begin
            read_word = ue_mask;
        end else begin
            read_word = WORD_ZERO;
        end
    end

    // Read data sampled on the wait cycle, stands until next read
    always_ff @(posedge clock) begin
        if (!rstn) begin
            avs_readdata <= WORD_ZERO;
        end else if (rd_take) begin
            avs_readdata <= read_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write merge: only writable bits take the new value

    assign dc2_merge = (dc2_word & ~wmask) | (avs_writedata & wmask);
    assign lc2_merge = (lc2_word & ~wmask) | (avs_writedata & wmask);

    // Device control two, conventional reset
    always_ff @(posedge clock) begin
        if (!rstn) begin
            dev_ctrl.ltr_enable <= 1'b0;
            dev_ctrl.obff_enable <= OBFF_RST;
        end else if (wr_fire && hit(avs_address, OFS_DEV_CTRL2)) begin
            dev_ctrl.ltr_enable <= dc2_merge[DC2_LTR_EN];
            dev_ctrl.obff_enable <= dc2_merge[DC2_OBFF_LSB +: OBFF_W];
        end
    end

    // Link control two; speed change disable is plain RW, conventional
    // reset, so the whole struct keeps a single driving process
    always_ff @(posedge clock) begin
        if (!rstn) begin
            link_ctrl.hw_speed_change_disable <= 1'b0;
        end else if (wr_fire && hit(avs_address, OFS_LINK_CTRL2)) begin
            link_ctrl.hw_speed_change_disable <=
                lc2_merge[LC2_HW_SPEED_DIS];
        end
        // Sticky fields survive conventional and hot resets
        if (!sticky_rstn) begin
            link_ctrl.target_link_speed <= SPEED_RST;
            link_ctrl.enter_compliance <= 1'b0;
            link_ctrl.transmit_margin <= MARGIN_RST;
            link_ctrl.enter_modified_compliance <= 1'b0;
            link_ctrl.compliance_skip_ordered_sets <= 1'b0;
            link_ctrl.compliance_deemphasis <= 1'b0;
        end else if (wr_fire && hit(avs_address, OFS_LINK_CTRL2)) begin
            link_ctrl.target_link_speed <=
                lc2_merge[LC2_SPEED_LSB +: SPEED_W];
            link_ctrl.enter_compliance <= lc2_merge[LC2_ENTER_COMPL];
            link_ctrl.transmit_margin <=
                lc2_merge[LC2_MARGIN_LSB +: MARGIN_W];
            link_ctrl.enter_modified_compliance <=
                lc2_merge[LC2_MOD_COMPL];
            link_ctrl.compliance_skip_ordered_sets <=
                lc2_merge[LC2_COMPL_SOS];
            link_ctrl.compliance_deemphasis <= lc2_merge[LC2_COMPL_DEEMPH];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Uncorrectable error status and mask

    assign ue_set = uncor_word(uncor_events) & UE_IMPL_MASK;

    // Only ones in enabled lanes clear; zeros leave bits alone
    always_comb begin
        if (wr_fire && hit(avs_address, OFS_UE_STATUS)) begin
            ue_clear = avs_writedata & wmask & UE_IMPL_MASK;
        end else begin
            ue_clear = WORD_ZERO;
        end
    end

    // Set applied after clear so a coincident event is kept
    assign next_status = (ue_status & ~ue_clear) | ue_set;

    // Status is sticky; reserved positions never set
    always_ff @(posedge clock) begin
        if (!sticky_rstn) begin
            ue_status <= WORD_ZERO;
        end else begin
            ue_status <= next_status & UE_IMPL_MASK;
        end
    end

    // Mask is sticky read-write on implemented bits only
    always_ff @(posedge clock) begin
        if (!sticky_rstn) begin
            ue_mask <= WORD_ZERO;
        end else if (wr_fire && hit(avs_address, OFS_UE_MASK)) begin
            ue_mask <= ((ue_mask & ~wmask) | (avs_writedata & wmask))
                & UE_IMPL_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reporting toward logging and messaging

    // Masked errors still show in status but are not reported
    always_ff @(posedge clock) begin
        if (!rstn) begin
            header_log_req <= 1'b0;
            error_msg_req <= 1'b0;
        end else begin
            header_log_req <= |(ue_set & ~ue_mask);
            error_msg_req <= |(ue_set & ~ue_mask);
        end
    end

endmodule // cap2_aer_regs

// >>> tb/cap2_aer_checker.sv
`timescale 1ns/100ps
module cap2_aer_checker
    import cap2_aer_pkg::*;
#(
    parameter bit DOWNSTREAM_PORT = 1'b0 // Port direction strap
) (
    input wire logic clock, // Core clock
    input wire logic rstn, // Conventional reset
    input wire logic sticky_rstn, // Sticky reset
    input wire logic [ADDR_W-1:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    input wire logic [31:0] avs_readdata, // Read data
    input wire logic avs_waitrequest, // Stall
    input wire uncor_event_t uncor_events, // Event pulses
    input wire dev_ctrl_t dev_ctrl, // Device control
    input wire logic header_log_req, // Log pulse
    input wire logic error_msg_req // Message pulse
);
    ////////////////////////////////////////
    // Accepted read and write strobes
    logic rd_ok; // Read data valid now
    logic wr_ok; // Write lands this edge
    assign rd_ok = avs_read && !avs_waitrequest;
    assign wr_ok = avs_write && !avs_waitrequest;

    // Either reset masks all checks
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn || !sticky_rstn);

    chk_msg_pair: assert property (
        header_log_req == error_msg_req) else $error("log and msg differ");
    chk_quiet_log: assert property (
        uncor_events == '0 |=> !header_log_req) else $error("log w/o event");
    chk_hdr_id: assert property (
        rd_ok && avs_address == 12'h100 |-> avs_readdata[15:0] == 16'h0001)
        else $error("bad capability id");
    chk_hdr_next: assert property (
        rd_ok && avs_address == 12'h100 |-> avs_readdata[31:16] == 16'h1401)
        else $error("bad version or pointer");
    chk_ctrl_rsvd: assert property (
        rd_ok && avs_address == 12'h0e8 |->
        (avs_readdata & 32'hffff_9bff) == 32'h0000_0000)
        else $error("device control reserved set");
    chk_deemph_fixed: assert property (
        rd_ok && avs_address == 12'h0f0 |-> avs_readdata[6] ==
        DOWNSTREAM_PORT && avs_readdata[16] == DOWNSTREAM_PORT)
        else $error("de-emphasis bits wrong");
    chk_status_rsvd: assert property (
        rd_ok && avs_address == 12'h104 |->
        (avs_readdata & 32'hffc0_0fee) == 32'h0000_0000)
        else $error("status reserved set");
    chk_ltr_write: assert property (
        wr_ok && avs_address == 12'h0e8 && avs_byteenable[1] |=>
        dev_ctrl == {$past(avs_writedata[14:13]), $past(avs_writedata[10])})
        else $error("device control not written");
endmodule // cap2_aer_checker

bind cap2_aer_regs cap2_aer_checker #(.DOWNSTREAM_PORT(DOWNSTREAM_PORT))
    i_cap2_aer_checker (.clock(clock), .rstn(rstn),
    .sticky_rstn(sticky_rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .uncor_events(uncor_events), .dev_ctrl(dev_ctrl),
    .header_log_req(header_log_req), .error_msg_req(error_msg_req));

// >>> tb/test_cap2_aer_regs.sv
`timescale 1ns/100ps
module test_cap2_aer_regs import cap2_aer_pkg::*;;
    logic clock = 1'b0; // 25 MHz core clock
    logic rstn = 1'b0; // Conventional reset
    logic sticky_rstn = 1'b0; // Sticky reset
    logic avs_read = 1'b0; // Read request
    logic avs_write = 1'b0; // Write request
    logic [11:0] avs_address = 12'h000; // Byte address
    logic [31:0] avs_writedata = 32'h0000_0000; // Write data
    logic [3:0] avs_byteenable = 4'h0; // Byte lanes
    logic [31:0] avs_readdata; // Read data
    logic [31:0] rd; // Last read word
    logic [31:0] avs_readdata_up; // Read data, upstream copy
    logic [31:0] rd_up; // Last upstream read word
    logic [31:0] bit_k; // One status bit
    logic avs_waitrequest; // Stall
    logic header_log_req; // Log pulse
    logic error_msg_req; // Message pulse
    uncor_event_t uncor_events = '0; // Event pulses
    dev_ctrl_t dev_ctrl; // Device control outputs
    link_ctrl_t link_ctrl; // Link control outputs
    int fail_count = 0; // Mismatches
    int cmp_count = 0; // Comparisons
    typedef struct packed {logic [11:0] a; logic [31:0] d;} row_t;
    // Reset image of the whole slice, unmapped places included
    row_t rows [10] = '{'{12'h0e8, 32'h0000_0000},
        '{12'h0ec, 32'h0000_0000}, '{12'h0f0, 32'h0001_0042},
        '{12'h0f4, 32'h0000_0000}, '{12'h0f8, 32'h0000_0000},
        '{12'h100, 32'h1401_0001}, '{12'h104, 32'h0000_0000},
        '{12'h108, 32'h0000_0000}, '{12'h10c, 32'h0000_0000},
        '{12'h200, 32'h0000_0000}};
    int pos [12] = '{0, 4, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21};

    always #20 clock = ~clock;

    // Downstream strap so de-emphasis reads one
    cap2_aer_regs #(.DOWNSTREAM_PORT(1'b1)) i_cap2_aer_regs (
        .clock(clock), .rstn(rstn), .sticky_rstn(sticky_rstn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .uncor_events(uncor_events),
        .dev_ctrl(dev_ctrl), .link_ctrl(link_ctrl),
        .header_log_req(header_log_req), .error_msg_req(error_msg_req));

    // Upstream strap copy, driven alike, so de-emphasis reads zero
    cap2_aer_regs #(.DOWNSTREAM_PORT(1'b0)) i_cap2_aer_regs_up (
        .clock(clock), .rstn(rstn), .sticky_rstn(sticky_rstn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata_up),
        .avs_waitrequest(), .uncor_events(uncor_events),
        .dev_ctrl(), .link_ctrl(),
        .header_log_req(), .error_msg_req());

    ////////////////////////////////////////
    // Verdict and end of run
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    // One bus access; held until waitrequest is seen low
    task automatic acc(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        rd_up = avs_readdata_up;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20) begin // Hung bus counts as a mismatch
            fail_count++;
            conclude();
        end
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0000_0000, 4'h0);
        check(rd, exp);
    endtask

    // Event high for exactly one edge; returns mid-cycle while the
    // one-cycle log pulse stands and has settled
    task automatic pulse(input uncor_event_t ev);
        @(posedge clock);
        uncor_events <= ev;
        @(posedge clock);
        uncor_events <= '0;
        @(negedge clock);
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        sticky_rstn <= 1'b1;
        foreach (rows[i]) rdchk(rows[i].a, rows[i].d);
        rdchk(OFS_LINK_CTRL2, 32'h0001_0042);
        check(rd_up, 32'h0000_0002);
        // All ones: only writable fields may stick
        acc(1'b1, OFS_DEV_CTRL2, 32'hffff_ffff, 4'hf);
        rdchk(OFS_DEV_CTRL2, 32'h0000_6400);
        check({29'h0, dev_ctrl}, 32'h0000_0007);
        acc(1'b1, OFS_LINK_CTRL2, 32'hffff_ffff, 4'hf);
        rdchk(OFS_LINK_CTRL2, 32'h0001_1fff);
        check({20'h0, link_ctrl}, 32'h0000_0fff);
        acc(1'b1, OFS_AER_HDR, 32'hffff_ffff, 4'hf);
        rdchk(OFS_AER_HDR, 32'h1401_0001);
        // Each source: set, logged, zero write keeps, one clears
        foreach (pos[k]) begin
            bit_k = 32'h0000_0001 << pos[k];
            pulse(12'h001 << k);
            check({31'h0, header_log_req}, 32'h0000_0001);
            check({31'h0, error_msg_req}, 32'h0000_0001);
            rdchk(OFS_UE_STATUS, bit_k);
            acc(1'b1, OFS_UE_STATUS, 32'h0000_0000, 4'hf);
            rdchk(OFS_UE_STATUS, bit_k);
            acc(1'b1, OFS_UE_STATUS, bit_k, 4'hf);
            rdchk(OFS_UE_STATUS, 32'h0000_0000);
        end
        // Masked events still set status but raise nothing
        acc(1'b1, OFS_UE_MASK, 32'hffff_ffff, 4'hf);
        rdchk(OFS_UE_MASK, 32'h003f_f011);
        pulse(12'hfff);
        check({31'h0, header_log_req}, 32'h0000_0000);
        check({31'h0, error_msg_req}, 32'h0000_0000);
        rdchk(OFS_UE_STATUS, 32'h003f_f011);
        acc(1'b1, OFS_UE_STATUS, 32'hffff_ffff, 4'h1);
        rdchk(OFS_UE_STATUS, 32'h003f_f000);
        // Clear while the event is still firing: set wins
        @(posedge clock);
        uncor_events <= 12'h001;
        acc(1'b1, OFS_UE_STATUS, 32'hffff_ffff, 4'hf);
        uncor_events <= '0;
        rdchk(OFS_UE_STATUS, 32'h0000_0001);
        // Conventional reset spares sticky state
        pulse(12'h002);
        @(posedge clock);
        rstn <= 1'b0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        check({29'h0, dev_ctrl}, 32'h0000_0000);
        check({20'h0, link_ctrl}, 32'h0000_0fbf);
        rdchk(OFS_UE_STATUS, 32'h0000_0011);
        rdchk(OFS_LINK_CTRL2, 32'h0001_1fdf);
        sticky_rstn <= 1'b0;
        repeat (3) @(posedge clock);
        sticky_rstn <= 1'b1;
        check({20'h0, link_ctrl}, 32'h0000_0200);
        rdchk(OFS_UE_STATUS, 32'h0000_0000);
        rdchk(OFS_LINK_CTRL2, 32'h0001_0042);
        conclude();
    end
endmodule // test_cap2_aer_regs
